/* File: common/audio_serial_consts.svh */
// Named constants for the serial audio port controller.
// Assumes inclusion by bare name from the package and the design file.
`ifndef AUDIO_SERIAL_CONSTS_SVH
`define AUDIO_SERIAL_CONSTS_SVH

// Buffer geometry
`define FIFO_DEPTH      8
`define WORD_BITS       32
`define LEVEL_BITS      4
`define THRESH_BITS     3

// Sample width setting codes and the matching bit counts
`define WIDTH_8         2'h0
`define WIDTH_16        2'h1
`define WIDTH_24        2'h2
`define WIDTH_32        2'h3
`define BITS_8          6'h08
`define BITS_16         6'h10
`define BITS_24         6'h18
`define BITS_32         6'h20
`define POS_MAX         6'h3f

// Data formats and the delay of the first data bit after a word-select edge
`define FMT_I2S         1'h0
`define FMT_MSB         1'h1
`define I2S_DELAY       6'h01
`define MSB_DELAY       6'h00

// Word-select level per channel
`define CH_LEFT         1'h0
`define CH_RIGHT        1'h1

// Event flag positions
`define EV_COUNT        8
`define EV_TX_OVF       0
`define EV_TX_UDF       1
`define EV_ZC_LEFT      2
`define EV_ZC_RIGHT     3
`define EV_RX_OVF       4
`define EV_RX_UDF       5
`define EV_TX_THR       6
`define EV_RX_THR       7
`define TX_EVENT_MASK   8'h4f
`define RX_EVENT_MASK   8'hb0
`define EV_RESET        8'h00

`endif

/* File: common/audio_serial_pkg.sv */
// Types shared by the serial audio port controller.
// Assumes audio_serial_consts.svh is reachable on the include path.
`include "audio_serial_consts.svh"

package audio_serial_pkg;

	typedef struct packed {
		logic       enable;
		logic       master_mode;
		logic       stereo_mode;
		logic       data_format;
		logic [1:0] sample_width_setting;
	} cfg_type;

	// Toggles passed from the link domain to the system domain
	typedef struct packed {
		logic tx_got;
		logic udf;
		logic zc_left;
		logic zc_right;
		logic rx_put;
	} link_toggle_type;

	typedef struct packed {
		logic                    ws_prev;
		logic                    ws_drive;
		logic [5:0]              pos;
		logic                    chan;
		logic [`WORD_BITS-1:0]   tx_shift;
		logic                    tx_bit;
		logic [1:0]              last_sign;
		logic [`WORD_BITS-1:0]   rx_acc;
		logic [5:0]              rx_cnt;
		logic                    rx_chan;
		logic [`WORD_BITS-1:0]   rx_hold;
		link_toggle_type         tgl;
	} link_state_type;

	typedef struct packed {
		logic [`WORD_BITS-1:0]   tx_hold;
		logic                    tx_put;
		logic                    rx_got;
		logic                    udf_seen;
		logic                    zcl_seen;
		logic                    zcr_seen;
		logic                    tx_thr_prev;
		logic                    rx_thr_prev;
		logic [`EV_COUNT-1:0]    events;
		logic                    tx_summary;
		logic                    rx_summary;
		logic                    tx_dma;
		logic                    rx_dma;
		logic [1:0]              clk_sel;
		logic                    pins_oe;
	} ref_state_type;

endpackage : audio_serial_pkg

/* File: src/audio_serial_port_controller.sv */
// Serial audio port controller: sample buffers, link engine and event flags.
// Assumes link_bclk is the audio clock picked by audio_clock_select outside,
// never faster than ref_clk, and that config inputs change only while disabled.
//
// Contract
// [R01] Separate eight-word transmit and receive buffers
// [R02] Sample widths of 8, 16, 24, 32
// [R03] Master drives word select, slave follows
// [R04] Mono or stereo transfer
// [R05] Word select marks the current channel
// [R06] Bits per channel equal sample width
// [R07] Samples travel most significant bit first
// [R08] Drive on falling, sample on rising edge
// [R09] I2S format: MSB one clock late
// [R10] MSB-justified format: MSB without delay
// [R11] Two-bit field picks one of four clocks
// [R12] Audio clock not faster than system clock
// [R13] Transmit zero-cross, threshold, overflow, underflow events
// [R14] Receive threshold, overflow, underflow events
// [R15] Threshold crossing raises flag per buffer
// [R16] Separate transmit and receive DMA requests
// [R17] Transmit and receive summary flags
// [R18] Sign change per channel flags zero-cross
// [R19] Full buffer drops word, sets overflow
`timescale 1ns/100ps
`include "audio_serial_consts.svh"

module sync_bits #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_type;

	sync_state_type s;
	sync_state_type next_s;

	always_comb begin
		next_s.stage1 = d;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign q = s.stage2;
endmodule : sync_bits

module falling_edge_driver #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s;

	// Launching on the falling edge gives the far end half a period of setup
	always_ff @(negedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= d; // see [R08]
		end
	end

	assign q = s;
endmodule : falling_edge_driver

module sample_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic                     clk,
	input  wire logic                     resetn,
	input  wire logic                     clear,
	input  wire logic                     in_valid,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          in_ready,
	output logic                          out_valid,
	output logic      [WIDTH-1:0]         out_data,
	input  wire logic                     out_ready,
	output logic      [$clog2(DEPTH):0]   level
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 count;
		logic                        in_ready;
		logic                        out_valid;
		logic [WIDTH-1:0]            out_data;
	} fifo_state_type;

	fifo_state_type s;
	fifo_state_type next_s;
	logic           push;
	logic           pop;

	always_comb begin
		next_s = s;
		push = in_valid & s.in_ready;
		pop = out_ready & s.out_valid;
		if (clear) begin
			next_s.wr = '0;
			next_s.rd = '0;
			next_s.count = '0;
		end else begin
			if (push) begin
				next_s.mem[s.wr] = in_data;
				next_s.wr = AW'(s.wr + 1'b1);
			end
			if (pop) begin
				next_s.rd = AW'(s.rd + 1'b1);
			end
			if (push && !pop) begin
				next_s.count = (AW+1)'(s.count + 1'b1);
			end else if (pop && !push) begin
				next_s.count = (AW+1)'(s.count - 1'b1);
			end
		end
		next_s.in_ready = (next_s.count != (AW+1)'(DEPTH));
		next_s.out_valid = (next_s.count != '0);
		// Head word is registered so the read port comes straight from flops
		next_s.out_data = next_s.mem[next_s.rd];
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.in_ready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign in_ready = s.in_ready;
	assign out_valid = s.out_valid;
	assign out_data = s.out_data;
	assign level = s.count;
endmodule : sample_fifo

module audio_serial_port_controller (
	// Clocks and reset
	input  wire logic                      ref_clk,
	input  wire logic                      resetn,
	input  wire logic                      link_bclk,
	// Configuration
	input  wire audio_serial_pkg::cfg_type cfg,
	input  wire logic [1:0]                clock_source_select,
	input  wire logic [`THRESH_BITS-1:0]   tx_threshold,
	input  wire logic [`THRESH_BITS-1:0]   rx_threshold,
	input  wire logic                      tx_clear,
	input  wire logic                      rx_clear,
	input  wire logic [`EV_COUNT-1:0]      event_enable,
	input  wire logic [`EV_COUNT-1:0]      event_clear,
	// Transmit samples
	input  wire logic                      tx_valid,
	input  wire logic [`WORD_BITS-1:0]     tx_data,
	output logic                           tx_ready,
	// Receive samples
	output logic                           rx_valid,
	output logic      [`WORD_BITS-1:0]     rx_data,
	input  wire logic                      rx_ready,
	// Status
	output logic      [`EV_COUNT-1:0]      event_flags,
	output logic                           transmit_event_summary,
	output logic                           receive_event_summary,
	output logic      [`LEVEL_BITS-1:0]    tx_level,
	output logic      [`LEVEL_BITS-1:0]    rx_level,
	output logic                           tx_dma_request,
	output logic                           rx_dma_request,
	output logic      [1:0]                audio_clock_select,
	// Link pins
	output logic                           bclk_oe,
	input  wire logic                      ws_in,
	output logic                           ws_out,
	output logic                           ws_oe,
	input  wire logic                      sd_in,
	output logic                           sd_out
);
	audio_serial_pkg::ref_state_type   s;
	audio_serial_pkg::ref_state_type   next_s;
	audio_serial_pkg::link_state_type  l;
	audio_serial_pkg::link_state_type  next_l;
	audio_serial_pkg::link_toggle_type tgl_sync;
	audio_serial_pkg::cfg_type         cfg_link;
	logic                              tx_put_link;
	logic                              txf_out_valid;
	logic [`WORD_BITS-1:0]             txf_out_data;
	logic                              txf_out_ready;
	logic                              rxf_in_valid;
	logic                              rxf_in_ready;
	logic                              rxf_out_valid;
	logic [`EV_COUNT-1:0]              raw;
	logic                              tx_thr_now;
	logic                              rx_thr_now;
	logic                              ws_now;
	logic [5:0]                        bits;
	logic [5:0]                        dly;
	logic [5:0]                        pos_cur;
	logic                              ch_cur;
	logic [5:0]                        np;
	logic                              nch;
	logic                              tx_active;
	logic [`WORD_BITS-1:0]             aligned;

	sample_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH)) tx_fifo ( // see [R01]
		.clk       (ref_clk),
		.resetn    (resetn),
		.clear     (tx_clear),
		.in_valid  (tx_valid),
		.in_data   (tx_data),
		.in_ready  (tx_ready),
		.out_valid (txf_out_valid),
		.out_data  (txf_out_data),
		.out_ready (txf_out_ready),
		.level     (tx_level)
	);

	sample_fifo #(.WIDTH(`WORD_BITS), .DEPTH(`FIFO_DEPTH)) rx_fifo ( // see [R01]
		.clk       (ref_clk),
		.resetn    (resetn),
		.clear     (rx_clear),
		.in_valid  (rxf_in_valid),
		.in_data   (l.rx_hold),
		.in_ready  (rxf_in_ready),
		.out_valid (rxf_out_valid),
		.out_data  (rx_data),
		.out_ready (rx_ready),
		.level     (rx_level)
	);

	sync_bits #(.WIDTH(5)) link_to_ref (
		.clk    (ref_clk),
		.resetn (resetn),
		.d      (l.tgl),
		.q      (tgl_sync)
	);

	sync_bits #(.WIDTH(7)) ref_to_link (
		.clk    (link_bclk),
		.resetn (resetn),
		.d      ({cfg, s.tx_put}),
		.q      ({cfg_link, tx_put_link})
	);

	falling_edge_driver #(.WIDTH(2)) pin_driver (
		.clk    (link_bclk),
		.resetn (resetn),
		.d      ({l.ws_drive, l.tx_bit}),
		.q      ({ws_out, sd_out})
	);

	// System-clock side: hold-register refill, receive push, event flags
	always_comb begin
		next_s = s;
		raw = '0;
		// Hold register is free once the link has acknowledged the last word
		txf_out_ready = (s.tx_put == tgl_sync.tx_got);
		if (txf_out_valid && txf_out_ready) begin
			next_s.tx_hold = txf_out_data;
			next_s.tx_put = ~s.tx_put;
		end
		// Receive hold stays stable for a whole slot, well past the sync delay
		rxf_in_valid = (tgl_sync.rx_put != s.rx_got);
		next_s.rx_got = tgl_sync.rx_put;
		raw[`EV_RX_OVF] = rxf_in_valid & ~rxf_in_ready; // see [R19] [R14]
		raw[`EV_TX_OVF] = tx_valid & ~tx_ready; // see [R19] [R13]
		raw[`EV_RX_UDF] = rx_ready & ~rxf_out_valid; // see [R14]
		raw[`EV_TX_UDF] = (tgl_sync.udf != s.udf_seen); // see [R13]
		raw[`EV_ZC_LEFT] = (tgl_sync.zc_left != s.zcl_seen); // see [R13] [R18]
		raw[`EV_ZC_RIGHT] = (tgl_sync.zc_right != s.zcr_seen); // see [R13] [R18]
		next_s.udf_seen = tgl_sync.udf;
		next_s.zcl_seen = tgl_sync.zc_left;
		next_s.zcr_seen = tgl_sync.zc_right;
		tx_thr_now = (tx_level <= {1'b0, tx_threshold});
		rx_thr_now = (rx_level > {1'b0, rx_threshold});
		raw[`EV_TX_THR] = tx_thr_now & ~s.tx_thr_prev; // see [R15]
		raw[`EV_RX_THR] = rx_thr_now & ~s.rx_thr_prev; // see [R15]
		next_s.tx_thr_prev = tx_thr_now;
		next_s.rx_thr_prev = rx_thr_now;
		// A new event in the clearing cycle survives the clear
		next_s.events = (s.events & ~event_clear) | raw;
		next_s.tx_summary = |(next_s.events & event_enable & `TX_EVENT_MASK); // see [R17]
		next_s.rx_summary = |(next_s.events & event_enable & `RX_EVENT_MASK); // see [R17]
		next_s.tx_dma = cfg.enable & tx_thr_now; // see [R16]
		next_s.rx_dma = cfg.enable & rx_thr_now; // see [R16]
		next_s.clk_sel = clock_source_select; // see [R11]
		next_s.pins_oe = cfg.master_mode; // see [R03]
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.events <= `EV_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Link side, on the rising edge of the bit clock
	always_comb begin
		next_l = l;
		aligned = '0;
		case (cfg_link.sample_width_setting) // see [R02] [R06]
			`WIDTH_8:  bits = `BITS_8;
			`WIDTH_16: bits = `BITS_16;
			`WIDTH_24: bits = `BITS_24;
			default:   bits = `BITS_32;
		endcase
		dly = (cfg_link.data_format == `FMT_I2S) ? `I2S_DELAY : `MSB_DELAY; // see [R09] [R10]
		ws_now = cfg_link.master_mode ? l.ws_drive : ws_in; // see [R03]
		// Slot position restarts at every word-select edge
		if (ws_now != l.ws_prev) begin
			pos_cur = '0;
			ch_cur = ws_now; // see [R05]
		end else begin
			pos_cur = (l.pos == `POS_MAX) ? l.pos : 6'(l.pos + 1'b1);
			ch_cur = l.chan;
		end
		next_l.ws_prev = ws_now;
		next_l.pos = pos_cur;
		next_l.chan = ch_cur;
		// Predict the position driven at the coming falling edge
		if (6'(pos_cur + 1'b1) >= bits) begin
			np = '0;
			nch = ~ch_cur;
		end else begin
			np = 6'(pos_cur + 1'b1);
			nch = ch_cur;
		end
		if (cfg_link.master_mode) begin
			next_l.ws_drive = nch; // see [R03] [R05] [R06]
		end
		tx_active = cfg_link.enable & (cfg_link.stereo_mode | (nch == `CH_LEFT)); // see [R04]
		if (np == dly) begin
			if (tx_active && (tx_put_link != l.tgl.tx_got)) begin
				aligned = l.tx_shift;
				aligned = s.tx_hold << (6'(`BITS_32) - bits); // see [R07]
				next_l.tgl.tx_got = ~l.tgl.tx_got;
				if (nch == `CH_LEFT) begin
					if (aligned[`WORD_BITS-1] != l.last_sign[0]) begin
						next_l.tgl.zc_left = ~l.tgl.zc_left; // see [R18]
					end
					next_l.last_sign[0] = aligned[`WORD_BITS-1];
				end else begin
					if (aligned[`WORD_BITS-1] != l.last_sign[1]) begin
						next_l.tgl.zc_right = ~l.tgl.zc_right; // see [R18]
					end
					next_l.last_sign[1] = aligned[`WORD_BITS-1];
				end
			end else if (tx_active) begin
				next_l.tgl.udf = ~l.tgl.udf; // see [R13]
			end
			next_l.tx_bit = aligned[`WORD_BITS-1]; // see [R07] [R09] [R10]
			next_l.tx_shift = {aligned[`WORD_BITS-2:0], 1'b0};
		end else begin
			next_l.tx_bit = l.tx_shift[`WORD_BITS-1]; // see [R07]
			next_l.tx_shift = {l.tx_shift[`WORD_BITS-2:0], 1'b0};
		end
		// Receive: sampled on this rising edge
		if (pos_cur == dly) begin
			next_l.rx_acc = {{(`WORD_BITS-1){1'b0}}, sd_in}; // see [R08] [R09] [R10]
			next_l.rx_cnt = 6'h01;
			next_l.rx_chan = ch_cur;
		end else if ((l.rx_cnt != '0) && (l.rx_cnt < bits)) begin
			next_l.rx_acc = {l.rx_acc[`WORD_BITS-2:0], sd_in}; // see [R07]
			next_l.rx_cnt = 6'(l.rx_cnt + 1'b1);
		end
		if (next_l.rx_cnt == bits) begin
			next_l.rx_cnt = '0;
			if (cfg_link.enable && (cfg_link.stereo_mode || (next_l.rx_chan == `CH_LEFT))) begin
				next_l.rx_hold = next_l.rx_acc; // see [R06] [R04]
				next_l.tgl.rx_put = ~l.tgl.rx_put;
			end
		end
		if (!cfg_link.enable) begin
			next_l.tx_bit = 1'b0;
		end
	end

	always_ff @(posedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			l <= '0;
		end else begin
			l <= next_l;
		end
	end

	assign rx_valid = rxf_out_valid;
	assign event_flags = s.events;
	assign transmit_event_summary = s.tx_summary;
	assign receive_event_summary = s.rx_summary;
	assign tx_dma_request = s.tx_dma;
	assign rx_dma_request = s.rx_dma;
	assign audio_clock_select = s.clk_sel;
	assign ws_oe = s.pins_oe;
	assign bclk_oe = s.pins_oe;
endmodule : audio_serial_port_controller

/* File: tb/audio_codec_model.sv */
// Behavioural codec on the far side of the serial link.
// Assumes the bench makes the bit clock; received serial data is looped back.
`timescale 1ns/100ps

module audio_codec_model (
	// Link
	input  wire logic       bclk,
	input  wire logic       ws_line,
	input  wire logic       sd_dev,
	output logic            ws_codec,
	output logic            sd_codec,
	// Format
	input  wire logic       drive_ws,
	input  wire logic       fmt,
	input  wire logic [5:0] bits
);
	logic [32:0] cap[$];
	logic [31:0] acc  = '0;
	logic [5:0]  pos  = '0;
	logic [5:0]  n    = '0;
	logic [5:0]  cnt  = '0;
	logic        ws_p = 1'b0;
	logic        ch   = 1'b0;

	initial ws_codec = 1'b0;
	// Loopback lets one run check both directions
	assign sd_codec = sd_dev;
	always @(negedge bclk) begin
		if (drive_ws) begin
			cnt <= (cnt == bits - 6'h01) ? 6'h00 : cnt + 6'h01;
			if (cnt == bits - 6'h01) ws_codec <= ~ws_codec;
		end
	end
	always @(posedge bclk) begin
		pos = (ws_line != ws_p) ? 6'h00 : pos + 6'h01;
		ws_p = ws_line;
		if (pos == 6'(!fmt)) begin
			acc = 32'(sd_dev);
			n = 6'h01;
			ch = ws_line;
		end else if (n != 6'h00) begin
			acc = {acc[30:0], sd_dev};
			n = n + 6'h01;
		end
		if (n == bits) begin
			cap.push_back({ch, acc});
			n = 6'h00;
		end
	end
endmodule : audio_codec_model

/* File: tb/audio_serial_checker.sv */
// Port assertions for the serial audio port controller.
// Assumes cfg changes only while disabled and the bit clock runs a while after disable.
`timescale 1ns/100ps
`include "audio_serial_consts.svh"

module audio_serial_checker (
	// Clocks and reset
	input wire logic                      ref_clk,
	input wire logic                      resetn,
	input wire logic                      link_bclk,
	// Controls
	input wire audio_serial_pkg::cfg_type cfg,
	input wire logic [1:0]                clock_source_select,
	input wire logic [2:0]                tx_threshold,
	input wire logic [2:0]                rx_threshold,
	input wire logic [7:0]                event_enable,
	input wire logic [7:0]                event_clear,
	input wire logic                      tx_valid,
	input wire logic                      rx_ready,
	// Status
	input wire logic                      tx_ready,
	input wire logic                      rx_valid,
	input wire logic [7:0]                event_flags,
	input wire logic                      transmit_event_summary,
	input wire logic [3:0]                tx_level,
	input wire logic [3:0]                rx_level,
	input wire logic                      tx_dma_request,
	input wire logic                      rx_dma_request,
	input wire logic [1:0]                audio_clock_select,
	input wire logic                      bclk_oe,
	input wire logic                      ws_out
);
	logic [1:0] warm;
	logic [5:0] gap;
	logic [1:0] tgl;
	logic       ws_d;
	wire        tx_want = cfg.enable && tx_level <= 4'(tx_threshold);
	wire        rx_want = cfg.enable && rx_level > 4'(rx_threshold);
	wire  [5:0] bits = {3'(cfg.sample_width_setting) + 3'h1, 3'h0};

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) warm <= 2'h0;
		else if (warm != 2'h3) warm <= warm + 2'h1;
	end
	// Early word-select intervals after enable are not judged: the engine starts after a sync delay
	always_ff @(negedge link_bclk or negedge resetn) begin
		if (!resetn) begin
			gap <= 6'h00;
			tgl <= 2'h0;
			ws_d <= 1'b0;
		end else begin
			ws_d <= ws_out;
			gap <= (ws_out != ws_d) ? 6'h01 : gap + 6'h01;
			if (!cfg.enable) tgl <= 2'h0;
			else if (ws_out != ws_d && tgl != 2'h3) tgl <= tgl + 2'h1;
		end
	end

	sequence push_full_s;
		tx_valid && !tx_ready;
	endsequence
	sequence pop_empty_s;
		rx_ready && !rx_valid;
	endsequence

	tx_ovf_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		push_full_s |=> event_flags[0]) else $error("tx overflow flag missing");
	rx_udf_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		pop_empty_s |=> event_flags[5]) else $error("rx underflow flag missing");
	flag_sticky_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		1'b1 |=> ($past(event_flags) & ~$past(event_clear) & ~event_flags) == 8'h00)
		else $error("event flag dropped without clear");
	tx_summary_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		transmit_event_summary == |(event_flags & $past(event_enable) & `TX_EVENT_MASK))
		else $error("tx summary mismatch");
	tx_dma_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		warm == 2'h3 && tx_want == $past(tx_want) |-> tx_dma_request == tx_want)
		else $error("tx dma request mismatch");
	rx_dma_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		warm == 2'h3 && rx_want == $past(rx_want) |-> rx_dma_request == rx_want)
		else $error("rx dma request mismatch");
	clk_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		warm != 2'h0 |-> audio_clock_select == $past(clock_source_select)) else $error("clock select mismatch");
	level_cap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		tx_level <= 4'h8 && rx_level <= 4'h8) else $error("buffer level above eight");
	master_oe_a: assert property (@(posedge ref_clk) disable iff (!resetn)
		warm == 2'h3 && cfg.master_mode == $past(cfg.master_mode) |-> bclk_oe == cfg.master_mode)
		else $error("clock drive enable mismatch");
	ws_period_a: assert property (@(negedge link_bclk) disable iff (!resetn)
		cfg.master_mode && tgl == 2'h3 && ws_out != ws_d |-> gap == bits) else $error("word select period wrong");
endmodule : audio_serial_checker

bind audio_serial_port_controller audio_serial_checker audio_serial_checker_inst (
	.ref_clk, .resetn, .link_bclk, .cfg, .clock_source_select, .tx_threshold, .rx_threshold,
	.event_enable, .event_clear, .tx_valid, .rx_ready, .tx_ready, .rx_valid, .event_flags,
	.transmit_event_summary, .tx_level, .rx_level, .tx_dma_request, .rx_dma_request,
	.audio_clock_select, .bclk_oe, .ws_out);

/* File: tb/audio_serial_port_controller_tb.sv */
// Self-checking bench for the serial audio port controller.
// Assumes the codec model as far side; the bit clock stands still between runs.
`timescale 1ns/100ps
`include "audio_serial_consts.svh"
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin miscompares++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, sn); end end

module audio_serial_port_controller_tb;
	logic                      ref_clk = 1'b0, resetn = 1'b0, link_bclk = 1'b0, run = 1'b0;
	audio_serial_pkg::cfg_type cfg = '0;
	logic [1:0]                clock_source_select = '0;
	logic [2:0]                tx_threshold = '0, rx_threshold = '0;
	logic [7:0]                event_enable = '0, event_clear = '0;
	logic                      tx_clear = 1'b0, rx_clear = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
	logic [31:0]               tx_data = '0;
	logic                      tx_ready, rx_valid, transmit_event_summary, receive_event_summary;
	logic                      tx_dma_request, rx_dma_request, bclk_oe, ws_out, ws_oe, sd_out, ws_codec, sd_in;
	logic [31:0]               rx_data;
	logic [7:0]                event_flags;
	logic [3:0]                tx_level, rx_level;
	logic [1:0]                audio_clock_select, sg = '0;
	wire                       ws_in = ws_oe ? ws_out : ws_codec;
	wire  [5:0]                bits = {3'(cfg.sample_width_setting) + 3'h1, 3'h0};
	int                        miscompares = 0, num_checks = 0, seed = 66906, k;
	logic [31:0]               sent[$], got[$];

	audio_serial_port_controller audio_serial_port_controller_inst (
		.ref_clk, .resetn, .link_bclk, .cfg, .clock_source_select, .tx_threshold, .rx_threshold,
		.tx_clear, .rx_clear, .event_enable, .event_clear, .tx_valid, .tx_data, .tx_ready,
		.rx_valid, .rx_data, .rx_ready, .event_flags, .transmit_event_summary, .receive_event_summary,
		.tx_level, .rx_level, .tx_dma_request, .rx_dma_request, .audio_clock_select,
		.bclk_oe, .ws_in, .ws_out, .ws_oe, .sd_in, .sd_out);
	audio_codec_model audio_codec_model_inst (.bclk(link_bclk), .ws_line(ws_in), .sd_dev(sd_out),
		.ws_codec, .sd_codec(sd_in), .drive_ws(!cfg.master_mode), .fmt(cfg.data_format), .bits);

	initial forever #5 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #40 link_bclk = run & ~link_bclk;
	end
	initial begin
		#600000;
		miscompares++;
		conclude();
	end

	task automatic conclude();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude

	task automatic push(input logic [31:0] d);
		@(negedge ref_clk);
		tx_valid = 1'b1;
		tx_data = d;
		@(negedge ref_clk);
		tx_valid = 1'b0;
	endtask : push

	task automatic pulse_clr();
		@(negedge ref_clk);
		event_clear = 8'hff;
		tx_clear = 1'b1;
		rx_clear = 1'b1;
		@(negedge ref_clk);
		event_clear = 8'h00;
		tx_clear = 1'b0;
		rx_clear = 1'b0;
	endtask : pulse_clr

	task automatic run_case(input logic f, input logic [1:0] w, input logic st, input logic ms, input logic rd);
		logic [31:0] m, d;
		logic [32:0] e;
		logic [1:0]  zc;
		int          i, n, c;
		@(negedge ref_clk);
		cfg = '{1'b0, ms, st, f, w};
		tx_threshold = 3'($random(seed));
		rx_threshold = 3'($random(seed));
		event_enable = 8'($random(seed));
		pulse_clr();
		m = (bits == 6'h20) ? 32'hffff_ffff : (32'h1 << bits) - 32'h1;
		sent.delete();
		got.delete();
		audio_codec_model_inst.cap.delete();
		zc = '0;
		for (i = 0; i < 6; i++) begin
			d = (32'($random(seed)) & m) | 32'h1;
			sent.push_back(d);
			push(d);
		end
		cfg.enable = 1'b1;
		run = 1'b1;
		repeat (int'(bits) * 160) begin
			@(negedge ref_clk);
			if (rd && rx_valid === 1'b1 && !rx_ready) begin
				got.push_back(rx_data);
				rx_ready = 1'b1;
			end else rx_ready = 1'b0;
		end
		@(negedge ref_clk);
		cfg.enable = 1'b0;
		rx_ready = 1'b0;
		repeat (320) @(negedge ref_clk);
		run = 1'b0;
		n = 0;
		foreach (audio_codec_model_inst.cap[j]) begin
			e = audio_codec_model_inst.cap[j];
			if ((st || !e[32]) && (n > 0 || e[31:0] != 32'h0) && n < 6) begin
				if (n == 0) c = e[32];
				i = c ^ (st & n[0]);
				`CHK("tx word", sent[n], e[31:0])
				`CHK("tx chan", i[0], e[32])
				if (sent[n][bits - 6'h01] != sg[i]) zc[i] = 1'b1;
				sg[i] = sent[n][bits - 6'h01];
				n++;
			end
		end
		`CHK("tx count", 6, n)
		while (got.size() > 0 && got[0] === 32'h0) void'(got.pop_front());
		for (i = 0; i < 6 && rd; i++) `CHK("rx word", sent[i], got[i])
		if (!rd) `CHK("rx ovf", 1'b1, event_flags[4])
		if (!rd) `CHK("rx thr", 1'b1, event_flags[7])
		`CHK("tx udf", 1'b1, event_flags[1])
		if (zc[0]) `CHK("zc left", 1'b1, event_flags[2])
		if (zc[1]) `CHK("zc right", 1'b1, event_flags[3])
		if (tx_threshold < 3'h5) `CHK("tx thr", 1'b1, event_flags[6])
		`CHK("tx sum", |(event_flags & event_enable & `TX_EVENT_MASK), transmit_event_summary)
		`CHK("rx sum", |(event_flags & event_enable & `RX_EVENT_MASK), receive_event_summary)
	endtask : run_case

	initial begin
		repeat (6) @(negedge ref_clk);
		`CHK("rst ready", 1'b1, tx_ready)
		`CHK("rst flags", 8'h00, event_flags)
		resetn = 1'b1;
		for (k = 0; k < 4; k++) begin
			clock_source_select = 2'(k);
			repeat (2) @(negedge ref_clk);
			`CHK("clk sel", 2'(k), audio_clock_select)
		end
		rx_ready = 1'b1;
		@(negedge ref_clk);
		rx_ready = 1'b0;
		@(negedge ref_clk);
		`CHK("rx udf", 1'b1, event_flags[5])
		for (k = 0; k < 8; k++) run_case(k[2], k[1:0], 1'b1, 1'b1, 1'b1);
		run_case(`FMT_I2S, `WIDTH_16, 1'b1, 1'b0, 1'b1);
		run_case(`FMT_MSB, `WIDTH_24, 1'b0, 1'b1, 1'b1);
		run_case(`FMT_I2S, `WIDTH_8, 1'b0, 1'b1, 1'b0);
		pulse_clr();
		@(negedge ref_clk);
		tx_valid = 1'b1;
		repeat (10) begin
			tx_data = 32'($random(seed));
			@(negedge ref_clk);
		end
		tx_valid = 1'b0;
		@(negedge ref_clk);
		`CHK("full level", 4'h8, tx_level)
		`CHK("full ready", 1'b0, tx_ready)
		`CHK("tx ovf", 1'b1, event_flags[0])
		conclude();
	end
endmodule : audio_serial_port_controller_tb
